/* src/bch_latency.sv */
// Initiator latency counter that ends a tenure after the limit expires.
`timescale 1ns/10ps
`default_nettype none
module bch_latency (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] limit,
    input wire logic frame_start,
    input wire logic xfer_done,
    input wire logic gnt_n,
    output logic expired,
    output logic terminate
);
    bch_pkg::bch_lat_e state;
    logic [7:0] count;

    // ==========================================
    // Tenure counter.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= bch_pkg::bch_idle;
            count <= bch_pkg::rst_latency;
            terminate <= 1'b0;
        end else begin
            terminate <= 1'b0;
            case (state)
                bch_pkg::bch_idle: begin
                    if (frame_start) begin
                        count <= 8'h00;
                        state <= bch_pkg::bch_count;
                    end
                end
                bch_pkg::bch_count: begin
                    if (xfer_done) begin
                        state <= bch_pkg::bch_idle;
                    end else if (count >= limit) begin
                        state <= bch_pkg::bch_expired;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                bch_pkg::bch_expired: begin
                    if (xfer_done) begin
                        state <= bch_pkg::bch_idle;
                    end else if (gnt_n) begin
                        terminate <= 1'b1;
                        state <= bch_pkg::bch_idle;
                    end
                end
                default: begin
                    state <= bch_pkg::bch_idle;
                end
            endcase
        end
    end

    assign expired = (state == bch_pkg::bch_expired);
endmodule : bch_latency
`default_nettype wire

/* src/bch_pkg.sv */
// Package with offsets, reset values, field positions and carrier types of the bridge configuration header block.
//
// Function
// - Latency count restarts at FRAME, counts clocks
// - Expired count ends transaction when grant drops
// - Header type byte always reads 82h
// - Offsets 00h-7Fh header, 80h-FFh extension
// - Self-test byte always reads 00h
// - Window base bits 31-12 writable, low zero
// - All-ones write reads back FFFF F000h
// - Socket registers at 000h, legacy at 800h
// - Capability pointer reads A0h; PM at A0h/A4h
// - Bit 15 set on card-side parity error
// - Bit 14 set on card system error
// - Bit 13 set on received master abort
// - Bit 12 set on received target abort
// - Bit 11 set on signaled target abort
// - Bits 10-9 hardwired 01b, medium select
// - Bit 8 needs CPERR, mastership, parity enable
// - Bits 7-5 and 4-0 read zero
// - Sticky flags cleared only by writing 1 or by global reset
// - Status reads 0200h after global reset
package bch_pkg;
    localparam logic [7:0] off_latency = 8'h0d;
    localparam logic [7:0] off_header = 8'h0e;
    localparam logic [7:0] off_selftest = 8'h0f;
    localparam logic [7:0] off_window = 8'h10;
    localparam logic [7:0] off_cap = 8'h14;
    localparam logic [7:0] off_status = 8'h16;
    localparam logic [7:0] off_pm0 = 8'ha0;
    localparam logic [7:0] off_pm1 = 8'ha4;
    localparam logic [7:0] ext_first = 8'h80;
    localparam logic [7:0] rst_latency = 8'h00;
    localparam logic [7:0] val_header = 8'h82;
    localparam logic [7:0] val_selftest = 8'h00;
    localparam logic [7:0] val_cap = 8'ha0;
    localparam logic [31:0] rst_window = 32'h0000_0000;
    localparam logic [31:0] window_mask = 32'hffff_f000;
    localparam logic [11:0] legacy_offset = 12'h800;
    localparam logic [15:0] rst_status = 16'h0200;
    localparam logic [1:0] val_select_timing = 2'h1;
    localparam logic [15:0] sticky_mask = 16'hf900;
    localparam int bit_parity = 15;
    localparam int bit_serr = 14;
    localparam int bit_mabort = 13;
    localparam int bit_tabort_rx = 12;
    localparam int bit_tabort_tx = 11;
    localparam int bit_dpar = 8;

    typedef struct packed {
        logic parity_error;
        logic system_error;
        logic master_abort;
        logic target_abort_rx;
        logic target_abort_tx;
        logic perr_seen;
        logic was_master;
    } bch_events_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bch_cfg_req_s;

    typedef enum logic [1:0] {
        bch_idle = 2'b00,
        bch_count = 2'b01,
        bch_expired = 2'b11
    } bch_lat_e;
endpackage : bch_pkg

/* src/bch_regs.sv */
// Configuration header register bank of the bridge function.
`timescale 1ns/10ps
`default_nettype none
module bch_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic global_reset_pin,
    input wire bch_pkg::bch_cfg_req_s cfg_req,
    input wire bch_pkg::bch_events_s card_events,
    input wire logic parity_response_en,
    input wire logic [31:0] ext_rdata,
    input wire logic frame_start,
    input wire logic xfer_done,
    input wire logic gnt_n,
    input wire logic [31:0] mem_addr,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    output logic ext_sel,
    output logic latency_expired,
    output logic initiator_terminate,
    output logic socket_reg_hit,
    output logic legacy_socket_registers_hit,
    output logic [10:0] window_offset
);
    logic [7:0] initiator_latency_timer;
    logic [31:0] socket_window_base;
    logic [15:0] card_side_status;
    logic [15:0] next_status;
    logic [31:0] read_word;
    logic gr_meta;
    logic gr_sync;
    logic expired_w;
    logic terminate_w;

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction : dword_hit

    // ==========================================
    // Global reset pin synchroniser.
    always_ff @(posedge core_clk) begin
        gr_meta <= global_reset_pin;
        gr_sync <= gr_meta;
    end

    // ==========================================
    // Latency timer register.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            initiator_latency_timer <= bch_pkg::rst_latency;
        end else if (cfg_req.wr && dword_hit(cfg_req.addr, bch_pkg::off_latency) && cfg_req.be[1]) begin
            initiator_latency_timer <= cfg_req.wdata[15:8];
        end
    end

    // ==========================================
    // Socket window base register.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            socket_window_base <= bch_pkg::rst_window;
        end else if (cfg_req.wr && dword_hit(cfg_req.addr, bch_pkg::off_window)) begin
            socket_window_base <= merge_be(socket_window_base, cfg_req.wdata, cfg_req.be)
                & bch_pkg::window_mask;
        end
    end

    // ==========================================
    // Card-side status flags; set wins over clear.
    always_comb begin
        next_status = card_side_status;
        if (cfg_req.wr && dword_hit(cfg_req.addr, bch_pkg::off_status) && cfg_req.be[3]) begin
            next_status[15:11] = card_side_status[15:11] & ~cfg_req.wdata[31:27];
        end
        if (cfg_req.wr && dword_hit(cfg_req.addr, bch_pkg::off_status) && cfg_req.be[2]) begin
            next_status[bch_pkg::bit_dpar] = card_side_status[bch_pkg::bit_dpar] & ~cfg_req.wdata[24];
        end
        if (card_events.parity_error) begin
            next_status[bch_pkg::bit_parity] = 1'b1;
        end
        if (card_events.system_error) begin
            next_status[bch_pkg::bit_serr] = 1'b1;
        end
        if (card_events.master_abort) begin
            next_status[bch_pkg::bit_mabort] = 1'b1;
        end
        if (card_events.target_abort_rx) begin
            next_status[bch_pkg::bit_tabort_rx] = 1'b1;
        end
        if (card_events.target_abort_tx) begin
            next_status[bch_pkg::bit_tabort_tx] = 1'b1;
        end
        if (card_events.perr_seen && card_events.was_master && parity_response_en) begin
            next_status[bch_pkg::bit_dpar] = 1'b1;
        end
        next_status = (next_status & bch_pkg::sticky_mask) | bch_pkg::rst_status;
    end

    always_ff @(posedge core_clk) begin
        if (gr_sync) begin
            card_side_status <= bch_pkg::rst_status;
        end else begin
            card_side_status <= next_status;
        end
    end

    // ==========================================
    // Read decode.
    always_comb begin
        read_word = 32'h0000_0000;
        if (cfg_req.addr >= bch_pkg::ext_first) begin
            read_word = ext_rdata;
        end else if (dword_hit(cfg_req.addr, bch_pkg::off_latency)) begin
            read_word = {bch_pkg::val_selftest, bch_pkg::val_header, initiator_latency_timer, 8'h00};
        end else if (dword_hit(cfg_req.addr, bch_pkg::off_window)) begin
            read_word = socket_window_base & bch_pkg::window_mask;
        end else if (dword_hit(cfg_req.addr, bch_pkg::off_cap)) begin
            read_word = {card_side_status, 8'h00, bch_pkg::val_cap};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack <= 1'b0;
            ext_sel <= 1'b0;
        end else begin
            cfg_ack <= cfg_req.rd || cfg_req.wr;
            ext_sel <= (cfg_req.rd || cfg_req.wr) && (cfg_req.addr >= bch_pkg::ext_first);
            if (cfg_req.rd) begin
                cfg_rdata <= read_word;
            end
        end
    end

    // ==========================================
    // Socket window hit decode.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            socket_reg_hit <= 1'b0;
            legacy_socket_registers_hit <= 1'b0;
            window_offset <= 11'h000;
        end else begin
            socket_reg_hit <= 1'b0;
            legacy_socket_registers_hit <= 1'b0;
            if (socket_window_base != 32'h0000_0000 && mem_addr[31:12] == socket_window_base[31:12]) begin
                socket_reg_hit <= mem_addr[11:0] < bch_pkg::legacy_offset;
                legacy_socket_registers_hit <= mem_addr[11:0] >= bch_pkg::legacy_offset;
            end
            window_offset <= mem_addr[10:0];
        end
    end

    // ==========================================
    // Latency counter and registered outputs.
    bch_latency u_latency (
        .core_clk(core_clk),
        .rst(rst),
        .limit(initiator_latency_timer),
        .frame_start(frame_start),
        .xfer_done(xfer_done),
        .gnt_n(gnt_n),
        .expired(expired_w),
        .terminate(terminate_w)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            latency_expired <= 1'b0;
            initiator_terminate <= 1'b0;
        end else begin
            latency_expired <= expired_w;
            initiator_terminate <= terminate_w;
        end
    end
endmodule : bch_regs
`default_nettype wire

/* test/bch_card_model.sv */
// Card side model that raises bus events on command.
`timescale 1ns/10ps
`default_nettype none
module bch_card_model (
    input wire logic core_clk,
    input wire logic [6:0] fire,
    output bch_pkg::bch_events_s card_events
);
    // ==========================================
    // Each commanded event is registered and follows fire one clock later.
    always_ff @(posedge core_clk) begin
        card_events <= bch_pkg::bch_events_s'(fire);
    end
endmodule : bch_card_model
`default_nettype wire

/* test/bch_regs_chk.sv */
// Port checker of the configuration header register bank.
`timescale 1ns/10ps
`default_nettype none
module bch_regs_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire bch_pkg::bch_cfg_req_s cfg_req,
    input wire bch_pkg::bch_events_s card_events,
    input wire logic parity_response_en,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic ext_sel,
    input wire logic initiator_terminate,
    input wire logic socket_reg_hit,
    input wire logic legacy_socket_registers_hit
);
    // ==========================================
    // Assertions on the port behaviour.
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic acc;
    logic rd5;
    assign acc = cfg_req.rd || cfg_req.wr;
    assign rd5 = cfg_req.rd && cfg_req.addr[7:2] == 6'h05;
    sequence then_rd(e);
        e ##1 rd5;
    endsequence
    AST_ACK: assert property (acc |=> cfg_ack)
        else $error("no ack");
    AST_EXT: assert property (acc |=> ext_sel == $past(cfg_req.addr[7]))
        else $error("ext select wrong");
    AST_HDR: assert property (cfg_req.rd && cfg_req.addr[7:2] == 6'h03 |=> cfg_rdata[31:16] == 16'h0082)
        else $error("header bytes wrong");
    AST_WIN: assert property (cfg_req.rd && cfg_req.addr[7:2] == 6'h04 |=> cfg_rdata[11:0] == 12'h000)
        else $error("window low bits set");
    AST_CAP: assert property (rd5 |=> cfg_rdata[7:0] == 8'ha0)
        else $error("capability pointer wrong");
    AST_FIXED: assert property (rd5 |=> cfg_rdata[26:25] == 2'b01 && cfg_rdata[23:16] == 8'h00)
        else $error("status fixed bits wrong");
    AST_PAR: assert property (then_rd(card_events.parity_error) |=> cfg_rdata[31])
        else $error("parity flag missing");
    AST_DPAR: assert property (then_rd(card_events.perr_seen && card_events.was_master && parity_response_en)
        |=> cfg_rdata[24])
        else $error("data parity flag missing");
    AST_TERM: assert property (initiator_terminate |=> !initiator_terminate)
        else $error("terminate not a pulse");
    AST_HALF: assert property (legacy_socket_registers_hit |-> $past(mem_addr[11]) && !socket_reg_hit)
        else $error("legacy half wrong");
    AST_SOCK: assert property (socket_reg_hit |-> !$past(mem_addr[11]))
        else $error("socket half wrong");
endmodule : bch_regs_chk
`default_nettype wire

/* test/bridge_config_header_regs_tb.sv */
// Self-checking bench of the configuration header register bank.
`timescale 1ns/10ps
`default_nettype none
module bridge_config_header_regs_tb;
    // ==========================================
    // Stimulus, reference model and checks.
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic global_reset_pin = 1'b1;
    logic parity_response_en = 1'b0;
    logic frame_start = 1'b0, xfer_done = 1'b0, gnt_n = 1'b0;
    logic [6:0] fire = 7'h00;
    logic [31:0] ext_rdata = 32'h0, mem_addr = 32'h0, cfg_rdata, rd;
    bch_pkg::bch_cfg_req_s cfg_req = '0;
    bch_pkg::bch_events_s card_events;
    logic cfg_ack, ext_sel, latency_expired, initiator_terminate, socket_reg_hit, legacy_socket_registers_hit;
    logic [10:0] window_offset;
    logic [3:0] term_seen;
    int errors = 0, checks = 0, cycles = 0, sts = 'h200, lat = 0, win = 0, r;
    bch_regs dut (.*);
    bch_card_model card (.*);
    always #5 core_clk = ~core_clk;
    task automatic conclude();
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, want, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_req = '{w, !w, a, be, d};
        tick(1);
        cfg_req = '0;
        chk("ack", {31'h0, cfg_ack}, 32'h1);
        rd = cfg_rdata;
        tick(1);
    endtask : acc
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
        acc(1'b0, a, 4'h0, 32'h0);
        chk(n, rd & m, want);
    endtask : rchk
    task automatic regs();
        rchk("sts", 8'h14, 32'hffff_00ff, {sts[15:0], 16'h00a0});
        rchk("hdr", 8'h0c, 32'hffff_ff00, {16'h0082, lat[7:0], 8'h00});
        rchk("win", 8'h10, 32'hffff_ffff, win);
    endtask : regs
    task automatic evt(input logic [6:0] f);
        fire = f;
        tick(1);
        fire = 7'h00;
        tick(1);
    endtask : evt
    initial begin
        void'($urandom(47750));
        tick(3);
        rst = 1'b0;
        global_reset_pin = 1'b0;
        tick(4);
        regs();
        lat = $urandom_range(255);
        acc(1'b1, 8'h0c, 4'hf, {16'hffff, lat[7:0], 8'h00});
        acc(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
        win = 32'hffff_f000;
        acc(1'b1, 8'h14, 4'hf, 32'h06ff_ffff);
        regs();
        for (int i = 0; i < 5; i++) begin
            evt(7'h40 >> i);
            sts |= 'h8000 >> i;
            regs();
        end
        evt(7'h03);
        parity_response_en = 1'b1;
        evt(7'h02);
        regs();
        evt(7'h03);
        sts |= 'h100;
        regs();
        acc(1'b1, 8'h14, 4'hc, 32'h0);
        r = $urandom & 'hf900;
        acc(1'b1, 8'h16, 4'hc, r << 16);
        sts &= ~r;
        regs();
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        lat = 0;
        win = 0;
        regs();
        global_reset_pin = 1'b1;
        tick(2);
        global_reset_pin = 1'b0;
        tick(4);
        sts = 'h200;
        regs();
        win = $urandom & 'hffff_f000 | 'h1000;
        acc(1'b1, 8'h10, 4'hf, win | 'hfff);
        regs();
        r = $urandom_range(2047);
        mem_addr = win + 'h800 + r;
        tick(2);
        chk("legacy", {19'h0, legacy_socket_registers_hit, socket_reg_hit, window_offset}, {21'h2, r[10:0]});
        mem_addr = win + r;
        tick(2);
        chk("socket", {19'h0, legacy_socket_registers_hit, socket_reg_hit, window_offset}, {21'h1, r[10:0]});
        ext_rdata = $urandom;
        rchk("ext", 8'ha0, 32'hffff_ffff, ext_rdata);
        rchk("gap", 8'h7c, 32'hffff_ffff, 32'h0);
        lat = 8;
        acc(1'b1, 8'h0c, 4'h2, 32'h0000_0800);
        repeat (2) begin
            gnt_n = 1'b0;
            frame_start = 1'b1;
            tick(1);
            frame_start = 1'b0;
            tick(9);
            chk("early", {31'h0, latency_expired}, 32'h0);
            tick(1);
            chk("expired", {30'h0, latency_expired, initiator_terminate}, 32'h2);
            gnt_n = 1'b1;
            term_seen = 4'h0;
            repeat (4) begin
                tick(1);
                term_seen = {term_seen[2:0], initiator_terminate};
            end
            chk("term", {28'h0, term_seen}, 32'h4);
            xfer_done = 1'b1;
            tick(1);
            xfer_done = 1'b0;
        end
        regs();
        conclude();
    end
endmodule : bridge_config_header_regs_tb
bind bch_regs bch_regs_chk chk (.*);
`default_nettype wire
